//--- rtl/processor_hot_event_profile.sv
// processor-hot alert profile: source enables, discharge event, alert pulse
// and the per-pulse event status register
// assumes the management bus decoder outside presents one-cycle rd/wr
// strobes with address and data; other events arrive already deglitched
`timescale 1ns/1ps
`include "proc_hot_cfg.svh"

// Notes on behaviour
// - six-bit discharge threshold in bits 15:10, 512 mA per code step
// - discharge event when current exceeds threshold; reset code 100000
// - bits 9:8 pick discharge deglitch: 1.6 ms, 100 us, 6 ms, 12 ms
// - bits 6:0 enable alert sources; all zero disables the alert
// - without adapter only comparator, discharge, system voltage enables act
// - enable bit map fixed; only critical current enabled at reset
// - adapter-good source fires once on its rising edge
// - every event firing during a pulse sets its status bit
// - status clears on first host read after the pin returns high
// - status also clears when the pin falls to start a pulse
// - status bit map matches events; one means triggered
// - status is read-only; bits 15:7 read zero
// - with extension, pin stays low until host writes release bit zero
// - without extension, pulse lasts at least the selected minimum width
module processor_hot_event_profile
#(
  parameter logic [`CNT_W-1:0] DEG_CYC_0   = `CNT_W'(`DEG_SEL_0_US * `CLK_MHZ),
  parameter logic [`CNT_W-1:0] DEG_CYC_1   = `CNT_W'(`DEG_SEL_1_US * `CLK_MHZ),
  parameter logic [`CNT_W-1:0] DEG_CYC_2   = `CNT_W'(`DEG_SEL_2_US * `CLK_MHZ),
  parameter logic [`CNT_W-1:0] DEG_CYC_3   = `CNT_W'(`DEG_SEL_3_US * `CLK_MHZ),
  parameter logic [`CNT_W-1:0] WIDTH_CYC_0 =
    `CNT_W'(`WIDTH_SEL_0_US * `CLK_MHZ),
  parameter logic [`CNT_W-1:0] WIDTH_CYC_1 =
    `CNT_W'(`WIDTH_SEL_1_US * `CLK_MHZ),
  parameter logic [`CNT_W-1:0] WIDTH_CYC_2 =
    `CNT_W'(`WIDTH_SEL_2_US * `CLK_MHZ),
  parameter logic [`CNT_W-1:0] WIDTH_CYC_3 =
    `CNT_W'(`WIDTH_SEL_3_US * `CLK_MHZ)
)
(
  // clock and reset
  input  wire logic                  sys_clk,
  input  wire logic                  srst,
  // register access from the management bus decoder
  input  wire proc_hot_pkg::reg_req_t reg_req,
  output logic [`REG_W-1:0]          reg_rdata,
  // monitored conditions
  input  wire logic                  adapter_present,
  input  wire logic [`EVT_W-1:0]     event_level,
  input  wire logic [`THR_W-1:0]     discharge_current_code,
  // pulse controls held in the neighbouring option register
  input  wire logic                  alert_extension_enable,
  input  wire logic [`SEL_W-1:0]     alert_min_width_select,
  input  wire logic                  alert_release_request,
  // alert pin and decoded settings
  output logic                       processor_hot_alert_n,
  output logic [`THR_W-1:0]          discharge_current_threshold,
  output logic [`SEL_W-1:0]          discharge_deglitch_select
);

  function automatic logic [`CNT_W-1:0] pick4
  (
    input logic [`SEL_W-1:0] sel,
    input logic [`CNT_W-1:0] c0,
    input logic [`CNT_W-1:0] c1,
    input logic [`CNT_W-1:0] c2,
    input logic [`CNT_W-1:0] c3
  );
    case (sel)
      2'h0:    pick4 = c0;
      2'h1:    pick4 = c1;
      2'h2:    pick4 = c2;
      default: pick4 = c3;
    endcase
  endfunction

  proc_hot_pkg::option1_t     opt_ff;
  proc_hot_pkg::option1_t     nxt_opt;
  logic [`EVT_W-1:0]          status_ff;
  logic [`EVT_W-1:0]          nxt_status;
  logic [`REG_W-1:0]          rdata_ff;
  logic [`REG_W-1:0]          nxt_rdata;
  proc_hot_pkg::alert_state_t state_ff;
  proc_hot_pkg::alert_state_t nxt_state;
  logic [`CNT_W-1:0]          width_ff;
  logic [`CNT_W-1:0]          nxt_width;
  logic                       armed_ff;
  logic                       nxt_armed;
  logic                       adapter_ff;
  logic                       nxt_adapter;
  logic                       disch_filt;
  logic [`CNT_W-1:0]          deg_limit;
  logic [`CNT_W-1:0]          width_limit;
  logic [`EVT_W-1:0]          active;
  logic [`EVT_W-1:0]          eff_mask;
  logic [`EVT_W-1:0]          fire;
  logic                       status_rd;
  logic                       width_done;

  assign deg_limit = pick4(opt_ff.deglitch_sel, DEG_CYC_0, DEG_CYC_1,
                           DEG_CYC_2, DEG_CYC_3);
  assign width_limit = pick4(alert_min_width_select, WIDTH_CYC_0,
                             WIDTH_CYC_1, WIDTH_CYC_2, WIDTH_CYC_3);

  event_deglitch u_disch_deglitch
  (
    .sys_clk  (sys_clk),
    .srst     (srst),
    .raw      (discharge_current_code > opt_ff.threshold),
    .limit    (deg_limit),
    .filtered (disch_filt)
  );

  // event sources; adapter-good fires on its rising edge only
  always_comb
  begin
    active = event_level;
    active[`EVT_DISCHARGE] = disch_filt;
    active[`EVT_ADAPTER] = event_level[`EVT_ADAPTER] & ~adapter_ff;
    nxt_adapter = event_level[`EVT_ADAPTER];
    eff_mask = opt_ff.source_enable;
    if (!adapter_present)
      eff_mask = eff_mask & `NO_ADAPTER_KEEP;
    fire = active & eff_mask;
  end

  assign status_rd = reg_req.rd && (reg_req.addr == `STATUS_ADDR);
  assign width_done = (width_ff >= width_limit);

  // alert pulse and per-pulse status
  always_comb
  begin
    nxt_state  = state_ff;
    nxt_width  = width_ff;
    nxt_armed  = armed_ff;
    nxt_status = status_ff;
    case (state_ff)
      proc_hot_pkg::ALERT_HIGH:
      begin
        if (status_rd && armed_ff)
        begin
          nxt_status = `EVT_NONE;
          nxt_armed  = 1'b0;
        end
        if (fire != `EVT_NONE)
        begin
          nxt_state  = proc_hot_pkg::ALERT_LOW;
          nxt_status = fire;
          nxt_width  = '0;
          nxt_armed  = 1'b0;
        end
      end
      proc_hot_pkg::ALERT_LOW:
      begin
        nxt_status = status_ff | fire;
        if (!width_done)
          nxt_width = width_ff + `CNT_W'(1);
        if (alert_extension_enable)
        begin
          if (!alert_release_request)
          begin
            nxt_state = proc_hot_pkg::ALERT_HIGH;
            nxt_armed = 1'b1;
          end
        end
        else if (width_done && fire == `EVT_NONE)
        begin
          nxt_state = proc_hot_pkg::ALERT_HIGH;
          nxt_armed = 1'b1;
        end
      end
      default:
      begin
        nxt_state = proc_hot_pkg::ALERT_HIGH;
      end
    endcase
  end

  // register file
  always_comb
  begin
    nxt_opt   = opt_ff;
    nxt_rdata = rdata_ff;
    if (reg_req.wr && reg_req.addr == `OPTION1_ADDR)
      nxt_opt = reg_req.wdata & `OPTION1_WMASK;
    if (reg_req.rd)
    begin
      case (reg_req.addr)
        `OPTION1_ADDR: nxt_rdata = opt_ff;
        `STATUS_ADDR:
          nxt_rdata = {{(`REG_W-`EVT_W){1'b0}}, status_ff};
        default:       nxt_rdata = '0;
      endcase
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      opt_ff     <= `OPTION1_RESET;
      status_ff  <= `EVT_NONE;
      rdata_ff   <= '0;
      state_ff   <= proc_hot_pkg::ALERT_HIGH;
      width_ff   <= '0;
      armed_ff   <= 1'b0;
      adapter_ff <= nxt_adapter; // start at the pin level: no false edge
    end
    else
    begin
      opt_ff     <= nxt_opt;
      status_ff  <= nxt_status;
      rdata_ff   <= nxt_rdata;
      state_ff   <= nxt_state;
      width_ff   <= nxt_width;
      armed_ff   <= nxt_armed;
      adapter_ff <= nxt_adapter;
    end
  end

  assign reg_rdata = rdata_ff;
  assign processor_hot_alert_n = (state_ff != proc_hot_pkg::ALERT_LOW);
  assign discharge_current_threshold = opt_ff.threshold;
  assign discharge_deglitch_select = opt_ff.deglitch_sel;

endmodule

//--- rtl/proc_hot_cfg.svh
// constants for the processor-hot alert profile block
// assumes a 100 MHz sys_clk; all times are kept in microseconds
`ifndef PROC_HOT_CFG_SVH
`define PROC_HOT_CFG_SVH

`define CLK_MHZ            100
`define CNT_W              21
`define EVT_W              7
`define THR_W              6
`define SEL_W              2
`define REG_W              16
`define ADDR_W             8

`define STATUS_ADDR        8'h3A
`define OPTION1_ADDR       8'h3D
`define OPTION1_RESET      16'h8120
`define OPTION1_WMASK      16'hFF7F

`define EVT_COMPARATOR     6
`define EVT_CRITICAL       5
`define EVT_NOMINAL        4
`define EVT_DISCHARGE      3
`define EVT_SYSVOLT        2
`define EVT_BATTERY        1
`define EVT_ADAPTER        0
`define NO_ADAPTER_KEEP    7'h4C
`define EVT_NONE           7'h00

`define DEG_SEL_0_US       1600
`define DEG_SEL_1_US       100
`define DEG_SEL_2_US       6000
`define DEG_SEL_3_US       12000
`define WIDTH_SEL_0_US     100
`define WIDTH_SEL_1_US     1000
`define WIDTH_SEL_2_US     10000
`define WIDTH_SEL_3_US     5000

`endif

//--- rtl/proc_hot_pkg.sv
// types shared by the processor-hot alert profile block
// assumes proc_hot_cfg.svh supplies the field widths
`include "proc_hot_cfg.svh"

package proc_hot_pkg;

  typedef struct packed
  {
    logic [`THR_W-1:0] threshold;
    logic [`SEL_W-1:0] deglitch_sel;
    logic              reserved;
    logic [`EVT_W-1:0] source_enable;
  } option1_t;

  typedef struct packed
  {
    logic              rd;
    logic              wr;
    logic [`ADDR_W-1:0] addr;
    logic [`REG_W-1:0]  wdata;
  } reg_req_t;

  typedef enum logic [0:0]
  {
    ALERT_HIGH,
    ALERT_LOW
  } alert_state_t;

endpackage

//--- rtl/event_deglitch.sv
// deglitch filter: output rises once the input has stood high long enough
// assumes the input is synchronous to sys_clk
`timescale 1ns/1ps
`include "proc_hot_cfg.svh"

module event_deglitch
(
  // clock and reset
  input  wire logic              sys_clk,
  input  wire logic              srst,
  // filter
  input  wire logic              raw,
  input  wire logic [`CNT_W-1:0] limit,
  output logic                   filtered
);

  logic [`CNT_W-1:0] cnt_ff;
  logic [`CNT_W-1:0] nxt_cnt;
  logic              filt_ff;
  logic              nxt_filt;

  always_comb
  begin
    nxt_cnt  = cnt_ff;
    nxt_filt = 1'b0;
    if (!raw)
      nxt_cnt = '0;
    else if (cnt_ff < limit)
      nxt_cnt = cnt_ff + `CNT_W'(1);
    else
      nxt_filt = 1'b1;
  end

  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      cnt_ff  <= '0;
      filt_ff <= 1'b0;
    end
    else
    begin
      cnt_ff  <= nxt_cnt;
      filt_ff <= nxt_filt;
    end
  end

  assign filtered = filt_ff;

endmodule

//--- bench/proc_hot_monitor.sv
// port checker for the alert profile block, bound from the bench top
// assumes one clock, sys_clk, and synchronous active-high srst
`timescale 1ns/1ps
`include "proc_hot_cfg.svh"
module proc_hot_monitor
#(
  parameter logic [20:0] W0 = 21'h0_0008,
  parameter logic [20:0] W1 = 21'h0_0009,
  parameter logic [20:0] W2 = 21'h0_000A,
  parameter logic [20:0] W3 = 21'h0_000B
)
(
  // clock and reset
  input wire logic                   sys_clk,
  input wire logic                   srst,
  // register access
  input wire proc_hot_pkg::reg_req_t reg_req,
  input wire logic [`REG_W-1:0]      reg_rdata,
  // conditions and pulse controls
  input wire logic                   adapter_present,
  input wire logic [`EVT_W-1:0]      event_level,
  input wire logic [`THR_W-1:0]      discharge_current_code,
  input wire logic                   alert_extension_enable,
  input wire logic [`SEL_W-1:0]      alert_min_width_select,
  input wire logic                   alert_release_request,
  // outputs
  input wire logic                   processor_hot_alert_n,
  input wire logic [`THR_W-1:0]      discharge_current_threshold,
  input wire logic [`SEL_W-1:0]      discharge_deglitch_select
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (srst);
  logic [20:0] low_cnt_ff;
  logic [20:0] nxt_low_cnt;
  logic [20:0] lim;
  always_comb
  begin
    nxt_low_cnt = processor_hot_alert_n ? 21'h0_0000 : low_cnt_ff + 21'h0_0001;
    case (alert_min_width_select)
      2'h0:    lim = W0;
      2'h1:    lim = W1;
      2'h2:    lim = W2;
      default: lim = W3;
    endcase
  end
  always_ff @(posedge sys_clk)
    low_cnt_ff <= srst ? 21'h0_0000 : nxt_low_cnt;
  a_reset_defaults: assert property ($fell(srst) |->
    discharge_current_threshold == 6'h20 && discharge_deglitch_select == 2'h1)
    else $error("option fields wrong after reset");
  a_write_fields: assert property (reg_req.wr && reg_req.addr == 8'h3D |=>
    {discharge_current_threshold, discharge_deglitch_select}
      == $past(reg_req.wdata[15:8])) else $error("option write lost");
  a_read_option: assert property (reg_req.rd && reg_req.addr == 8'h3D |=>
    reg_rdata[15:7] == {$past(discharge_current_threshold),
      $past(discharge_deglitch_select), 1'b0}) else $error("option read bad");
  a_status_reserved: assert property (reg_req.rd && reg_req.addr == 8'h3A |=>
    reg_rdata[15:7] == 9'h000) else $error("status upper bits set");
  a_min_width_kept: assert property ($rose(processor_hot_alert_n) &&
    !alert_extension_enable |-> low_cnt_ff >= lim) else $error("pulse short");
  a_ext_holds_low: assert property (alert_extension_enable &&
    !processor_hot_alert_n && alert_release_request &&
    $past(alert_release_request) |=> !processor_hot_alert_n)
    else $error("extended pulse ended early");
  a_ext_release: assert property (alert_extension_enable &&
    !processor_hot_alert_n && !alert_release_request && event_level == 7'h00
    && discharge_current_code == 6'h00 |-> ##[1:2] processor_hot_alert_n)
    else $error("release ignored");
  a_alert_needs_event: assert property ($fell(processor_hot_alert_n) |->
    $past(event_level) != 7'h00 ||
    $past(discharge_current_code) > $past(discharge_current_threshold))
    else $error("pulse without event");
  c_pulse: cover property ($fell(processor_hot_alert_n));
  c_ext_end: cover property ($rose(processor_hot_alert_n) &&
    alert_extension_enable);
  c_status: cover property (reg_req.rd ##1 reg_rdata[6:0] != 7'h00);
endmodule

//--- bench/proc_hot_host.sv
// host model: one-cycle read and write strobes toward the block
// assumes the block samples reg_req on the rising edge of sys_clk
`timescale 1ns/1ps
`include "proc_hot_cfg.svh"
module proc_hot_host
(
  // clock
  input  wire logic                   sys_clk,
  // requests and answers
  output proc_hot_pkg::reg_req_t      reg_req,
  input  wire logic [`REG_W-1:0]      reg_rdata
);
  initial reg_req = '0;
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge sys_clk);
    reg_req <= '{1'b0, 1'b1, a, d};
    @(posedge sys_clk);
    reg_req <= '0;
  endtask
  // data is taken mid-cycle once registered; returns on a rising edge so
  // the caller's next drive lands on the clock
  task automatic rd(input logic [7:0] a, output logic [15:0] d);
    @(posedge sys_clk);
    reg_req <= '{1'b1, 1'b0, a, 16'h0000};
    @(posedge sys_clk);
    reg_req <= '0;
    @(negedge sys_clk);
    d = reg_rdata;
    @(posedge sys_clk);
  endtask
endmodule

//--- bench/processor_hot_event_profile_tb_top.sv
// self-checking bench for the alert profile block
// assumes the host model drives register strobes; 100 MHz sys_clk
`timescale 1ns/1ps
`include "proc_hot_cfg.svh"
module processor_hot_event_profile_tb_top;
  logic        sys_clk = 0, srst = 1, adp = 1, ext = 0, rel = 1, alert_n, a;
  logic [6:0]  lvl = '0, hit;
  logic [5:0]  code = '0;
  logic [1:0]  wsel = '0;
  logic [15:0] rdata, got, v;
  int          n_mismatch = 0, tests_run = 0, i;
  proc_hot_pkg::reg_req_t req;
  always #5 sys_clk = ~sys_clk;
  // only the deglitch select that the bench uses for events is shortened
  processor_hot_event_profile #(.DEG_CYC_1(21'h0_0005),
    .WIDTH_CYC_0(21'h0_0008), .WIDTH_CYC_1(21'h0_0009),
    .WIDTH_CYC_2(21'h0_000A), .WIDTH_CYC_3(21'h0_000B))
  processor_hot_event_profile_i (.sys_clk(sys_clk), .srst(srst),
    .reg_req(req), .reg_rdata(rdata), .adapter_present(adp),
    .event_level(lvl), .discharge_current_code(code),
    .alert_extension_enable(ext), .alert_min_width_select(wsel),
    .alert_release_request(rel), .processor_hot_alert_n(alert_n),
    .discharge_current_threshold(), .discharge_deglitch_select());
  proc_hot_host proc_hot_host_i (.sys_clk(sys_clk), .reg_req(req),
    .reg_rdata(rdata));
  // sources left live with no adapter: comparator, discharge, system voltage
  function automatic logic [6:0] live(input logic [6:0] m, input logic p);
    return p ? m : m & 7'h4C;
  endfunction
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    tests_run++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("Error at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic rdchk(input logic [7:0] ad, input logic [15:0] e);
    proc_hot_host_i.rd(ad, got);
    chk(got, e);
  endtask
  task automatic wait_pin(input logic lv);
    @(negedge sys_clk);
    for (int k = 0; k < 200 && alert_n !== lv; k++)
      @(negedge sys_clk);
    chk(16'(alert_n), 16'(lv));
    @(posedge sys_clk);
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  initial
  begin
    repeat (20000) @(posedge sys_clk);
    n_mismatch++;
    tally_and_finish();
  end
  initial
  begin
    void'($urandom(76949));
    repeat (16) @(posedge sys_clk);
    srst <= 1'b0;
    rdchk(8'h3D, 16'h8120);
    rdchk(8'h3A, 16'h0000);
    $display("test reset done");
    proc_hot_host_i.wr(8'h3D, 16'h817F);
    for (int n = 0; n < 14; n++)
    begin
      i = n % 7;
      a = 1'($urandom);
      hit = live(7'h7F, a) & 7'(1 << i);
      @(posedge sys_clk);
      adp <= a;
      wsel <= 2'($urandom);
      lvl <= 7'(1 << i) & 7'h77;
      code <= (i == 3) ? 6'h3F : 6'h00;
      repeat (4) @(posedge sys_clk);
      @(negedge sys_clk);
      if (i == 3) chk(16'(alert_n), 16'h0001);
      repeat (26) @(posedge sys_clk);
      @(negedge sys_clk);
      v = (i == 0 || hit == 0) ? 16'h0001 : 16'h0000;
      chk(16'(alert_n), v);
      @(posedge sys_clk);
      lvl <= '0;
      code <= '0;
      wait_pin(1'b1);
      rdchk(8'h3A, 16'(hit));
      rdchk(8'h3A, 16'h0000);
    end
    $display("test sources done");
    @(posedge sys_clk);
    adp <= 1'b1;
    ext <= 1'b1;
    lvl <= 7'h20;
    repeat (3) @(posedge sys_clk);
    lvl <= 7'h00;
    repeat (40) @(posedge sys_clk);
    @(negedge sys_clk);
    chk(16'(alert_n), 16'h0000);
    @(posedge sys_clk);
    lvl <= 7'h40;
    repeat (3) @(posedge sys_clk);
    lvl <= 7'h00;
    rdchk(8'h3A, 16'h0060);
    rel <= 1'b0;
    wait_pin(1'b1);
    rel <= 1'b1;
    ext <= 1'b0;
    rdchk(8'h3A, 16'h0060);
    rdchk(8'h3A, 16'h0000);
    lvl <= 7'h40;
    repeat (3) @(posedge sys_clk);
    lvl <= 7'h00;
    wait_pin(1'b1);
    lvl <= 7'h04;
    repeat (3) @(posedge sys_clk);
    lvl <= 7'h00;
    wait_pin(1'b1);
    rdchk(8'h3A, 16'h0004);
    $display("test extension done");
    proc_hot_host_i.wr(8'h3D, 16'h8100);
    lvl <= 7'h7F;
    code <= 6'h3F;
    repeat (30) @(posedge sys_clk);
    @(negedge sys_clk);
    chk(16'(alert_n), 16'h0001);
    @(posedge sys_clk);
    lvl <= '0;
    code <= '0;
    rdchk(8'h3A, 16'h0000);
    $display("test masked done");
    repeat (4)
    begin
      v = 16'($urandom);
      proc_hot_host_i.wr(8'h3D, v);
      rdchk(8'h3D, v & 16'hFF7F);
      proc_hot_host_i.wr(8'h3A, v);
      rdchk(8'h3A, 16'h0000);
      rdchk(8'h3B, 16'h0000);
    end
    $display("test registers done");
    srst <= 1'b1;
    repeat (2) @(posedge sys_clk);
    srst <= 1'b0;
    rdchk(8'h3D, 16'h8120);
    rdchk(8'h3A, 16'h0000);
    $display("test second reset done");
    tally_and_finish();
  end
endmodule
bind processor_hot_event_profile proc_hot_monitor #(.W0(WIDTH_CYC_0),
  .W1(WIDTH_CYC_1), .W2(WIDTH_CYC_2), .W3(WIDTH_CYC_3)) proc_hot_monitor_i
  (.sys_clk(sys_clk), .srst(srst), .reg_req(reg_req), .reg_rdata(reg_rdata),
  .adapter_present(adapter_present), .event_level(event_level),
  .discharge_current_code(discharge_current_code),
  .alert_extension_enable(alert_extension_enable),
  .alert_min_width_select(alert_min_width_select),
  .alert_release_request(alert_release_request),
  .processor_hot_alert_n(processor_hot_alert_n),
  .discharge_current_threshold(discharge_current_threshold),
  .discharge_deglitch_select(discharge_deglitch_select));
